// ### core/hbec_pkg.sv
// Package: constants, field positions and carrier types of the bridge error-control bank
package hbec_pkg;

  // ----------------------------------------------------------------
  // Configuration access ports and register offsets
  // ----------------------------------------------------------------
  localparam logic [15:0] HBEC_CFG_ADDR_PORT   = 16'h0cf8;
  localparam logic [15:0] HBEC_CFG_DATA_PORT   = 16'h0cfc;
  localparam logic [7:0]  HBEC_OFS_HEADER_TYPE = 8'h0e;
  localparam logic [7:0]  HBEC_OFS_CTRL        = 8'h50;
  localparam logic [7:0]  HBEC_OFS_STATUS      = 8'h54;
  localparam logic [7:0]  HBEC_DWORD_MASK      = 8'hfc;

  // ----------------------------------------------------------------
  // Configuration address word fields
  // ----------------------------------------------------------------
  localparam int          HBEC_CA_ENABLE_BIT = 31;
  localparam int          HBEC_CA_BUS_LSB    = 16;
  localparam int          HBEC_CA_DEV_LSB    = 11;
  localparam int          HBEC_CA_FUNC_LSB   = 8;
  localparam logic [31:0] HBEC_CA_WR_MASK    = 32'h80fffffc;
  localparam logic [31:0] HBEC_CA_RESET      = 32'h00000000;

  // ----------------------------------------------------------------
  // Register values after reset and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0]  HBEC_HEADER_TYPE_VAL = 8'h00;
  localparam int          HBEC_HEADER_LSB      = 16;
  localparam logic [31:0] HBEC_CTRL_RESET      = 32'h00000000;
  localparam logic [31:0] HBEC_CTRL_WR_MASK    = 32'h0070001f;
  localparam logic [4:0]  HBEC_STATUS_RESET    = 5'h00;
  localparam int          HBEC_STATUS_WIDTH    = 5;
  localparam logic [31:0] HBEC_UNMAPPED_READ   = 32'hffffffff;

  localparam int HBEC_CTRL_LEGACY_COMPAT  = 22;
  localparam int HBEC_CTRL_READ_PREFETCH  = 21;
  localparam int HBEC_CTRL_WRITE_POSTING  = 20;
  localparam int HBEC_CTRL_PERR_RD_DATA   = 4;
  localparam int HBEC_CTRL_PERR_WR_DATA   = 3;
  localparam int HBEC_CTRL_PERR_ADDR      = 2;
  localparam int HBEC_CTRL_SERR_PARITY    = 1;
  localparam int HBEC_CTRL_SERR_TGT_ABORT = 0;

  localparam int HBEC_ST_RD_DATA_PARITY = 4;
  localparam int HBEC_ST_WR_DATA_PARITY = 3;
  localparam int HBEC_ST_ADDR_PARITY    = 2;
  localparam int HBEC_ST_PARITY_SYSERR  = 1;
  localparam int HBEC_ST_TGT_ABORT_SERR = 0;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } hbec_io_req_type;

  typedef struct packed {
    logic        valid;
    logic [31:0] rdata;
  } hbec_io_rsp_type;

  typedef struct packed {
    logic rd_data_parity;
    logic wr_data_parity;
    logic addr_parity;
    logic target_abort;
  } hbec_pci_evt_type;

  typedef struct packed {
    logic valid;
    logic is_write;
    logic qword_aligned;
    logic to_sysmem;
  } hbec_burst_req_type;

  typedef struct packed {
    logic prefetch;
    logic post;
    logic wait_complete;
    logic disconnect;
  } hbec_burst_dec_type;

  typedef enum logic [1:0] {
    HBEC_IO_IDLE = 2'b00,
    HBEC_IO_RESP = 2'b01
  } hbec_io_state_type;

  // Byte enables widened to a bit mask
  function automatic logic [31:0] hbec_be_mask(input logic [3:0] be);
    return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : hbec_be_mask

endpackage : hbec_pkg

// ### core/hbec_cfg_addr.sv
// Configuration address latch and target decode
`timescale 1ns/1ps
`default_nettype none
module hbec_cfg_addr #(
  parameter logic [4:0] DEVICE_NUM = 5'h00
) (
  // Clock and reset
  input  wire logic               i_sys_clk,
  input  wire logic               i_reset,
  // Write of the address port
  input  wire logic               i_addr_wr,
  input  wire logic [3:0]         i_be,
  input  wire logic [31:0]        i_wdata,
  // Decode
  output logic      [31:0]        o_cfg_addr_q,
  output logic                    o_hit,
  output logic      [7:0]         o_reg_ofs
);
  import hbec_pkg::*;

  typedef struct packed {
    logic [31:0] addr;
  } hbec_ca_state_type;

  hbec_ca_state_type state_q;
  hbec_ca_state_type state_d;

  always_comb begin
    logic [31:0] wmask;
    wmask   = hbec_be_mask(i_be) & HBEC_CA_WR_MASK;
    state_d = state_q;
    if (i_addr_wr) begin
      state_d.addr = (state_q.addr & ~wmask) | (i_wdata & wmask);
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      state_q.addr <= HBEC_CA_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  assign o_cfg_addr_q = state_q.addr;
  assign o_hit        = state_q.addr[HBEC_CA_ENABLE_BIT]
                      && (state_q.addr[HBEC_CA_BUS_LSB +: 8] == 8'h00)
                      && (state_q.addr[HBEC_CA_DEV_LSB +: 5] == DEVICE_NUM)
                      && (state_q.addr[HBEC_CA_FUNC_LSB +: 3] == 3'h0);
  assign o_reg_ofs    = state_q.addr[7:0] & HBEC_DWORD_MASK;

endmodule : hbec_cfg_addr
`default_nettype wire

// ### core/hbec_sticky_flags.sv
// Sticky write-one-to-clear flag bank
`timescale 1ns/1ps
`default_nettype none
module hbec_sticky_flags #(
  parameter int WIDTH = 5
) (
  // Clock and reset
  input  wire logic               i_sys_clk,
  input  wire logic               i_reset,
  // Events and clears
  input  wire logic [WIDTH-1:0]   i_set,
  input  wire logic [WIDTH-1:0]   i_clear,
  // Flags
  output logic      [WIDTH-1:0]   o_flags_q
);
  import hbec_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] flags;
  } hbec_fl_state_type;

  hbec_fl_state_type state_q;
  hbec_fl_state_type state_d;

  always_comb begin
    // Set wins over a coincident clear
    state_d.flags = (state_q.flags & ~i_clear) | i_set;
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      state_q.flags <= WIDTH'(HBEC_STATUS_RESET);
    end else begin
      state_q <= state_d;
    end
  end

  assign o_flags_q = state_q.flags;

endmodule : hbec_sticky_flags
`default_nettype wire

// ### core/hbec_bridge_err_ctrl.sv
// Host bridge control and PCI error reporting configuration registers
`timescale 1ns/1ps
`default_nettype none
module hbec_bridge_err_ctrl #(
  parameter logic [4:0] DEVICE_NUM = 5'h00
) (
  // Clock and reset
  input  wire logic                        i_sys_clk,
  input  wire logic                        i_reset,
  // Host I/O port access
  input  wire hbec_pkg::hbec_io_req_type   i_io_req,
  output var  hbec_pkg::hbec_io_rsp_type   o_io_rsp,
  // PCI error events
  input  wire hbec_pkg::hbec_pci_evt_type  i_pci_evt,
  // PCI error pins
  output logic                             o_perr_n,
  output logic                             o_perr_oe,
  output logic                             o_serr_n,
  output logic                             o_serr_oe,
  // Bridge mode levels
  output logic                             o_legacy_compat,
  output logic                             o_read_prefetch_en,
  output logic                             o_write_posting_en,
  // Burst handling from PCI masters
  input  wire hbec_pkg::hbec_burst_req_type i_burst_req,
  output var  hbec_pkg::hbec_burst_dec_type o_burst_dec
);
  import hbec_pkg::*;

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (DEVICE_NUM > 5'h1f) begin : g_bad_dev
    $error("Device number out of range");
  end
  if ((HBEC_STATUS_WIDTH < 1) || (HBEC_STATUS_WIDTH > 32)) begin : g_bad_status_width
    $error("Status width outside the register");
  end
  if (HBEC_ST_RD_DATA_PARITY >= HBEC_STATUS_WIDTH) begin : g_bad_status_pos
    $error("Status flag outside the flag bank");
  end
  if (HBEC_HEADER_LSB + 8 > 32) begin : g_bad_header_pos
    $error("Header type byte outside the dword");
  end
  if (HBEC_CTRL_LEGACY_COMPAT > 31) begin : g_bad_mode_pos
    $error("Mode bit outside the control register");
  end
  if (HBEC_CTRL_WR_MASK[31:23] != 9'h000) begin : g_bad_ctrl_mask
    $error("Reserved control bits made writable");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    hbec_io_state_type  io_st;
    hbec_io_rsp_type    rsp;
    logic [31:0]        ctrl;
    logic               perr_n;
    logic               perr_oe;
    logic               serr_n;
    logic               serr_oe;
    logic               legacy;
    logic               prefetch_en;
    logic               posting_en;
    hbec_burst_dec_type dec;
  } hbec_top_state_type;

  hbec_top_state_type state_q;
  hbec_top_state_type state_d;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  // Strobe aimed at one I/O port
  function automatic logic port_access(
    input logic        strobe,
    input logic [15:0] addr,
    input logic [15:0] port
  );
    return strobe && (addr == port);
  endfunction : port_access

  // Answer to a port read, last data kept otherwise
  function automatic hbec_io_rsp_type read_answer(
    input logic            rd_addr,
    input logic            rd_data,
    input logic [31:0]     addr_word,
    input logic [31:0]     reg_word,
    input hbec_io_rsp_type held
  );
    hbec_io_rsp_type rsp;
    rsp       = held;
    rsp.valid = rd_addr || rd_data;
    if (rd_addr) begin
      rsp.rdata = addr_word;
    end else if (rd_data) begin
      rsp.rdata = reg_word;
    end
    return rsp;
  endfunction : read_answer

  // Decision for one burst from a PCI master
  function automatic hbec_burst_dec_type burst_decide(
    input hbec_burst_req_type req,
    input logic [31:0]        ctrl
  );
    hbec_burst_dec_type dec;
    dec = '0;
    if (req.valid && req.to_sysmem) begin
      if (req.is_write) begin
        if (ctrl[HBEC_CTRL_WRITE_POSTING]) begin
          dec.post = 1'b1;
        end else begin
          dec.wait_complete = 1'b1;
          dec.disconnect    = 1'b1;
        end
      end else begin
        if (ctrl[HBEC_CTRL_READ_PREFETCH]) begin
          dec.prefetch = req.qword_aligned;
        end else begin
          dec.wait_complete = 1'b1;
          dec.disconnect    = 1'b1;
        end
      end
    end
    return dec;
  endfunction : burst_decide

  // ----------------------------------------------------------------
  // Configuration address decode
  // ----------------------------------------------------------------
  logic        addr_port_wr;
  logic        data_port_wr;
  logic        data_port_rd;
  logic        addr_port_rd;
  logic [31:0] cfg_addr;
  logic        cfg_hit;
  logic [7:0]  reg_ofs;

  assign addr_port_wr = port_access(i_io_req.wr, i_io_req.addr, HBEC_CFG_ADDR_PORT);
  assign addr_port_rd = port_access(i_io_req.rd, i_io_req.addr, HBEC_CFG_ADDR_PORT);
  assign data_port_wr = port_access(i_io_req.wr, i_io_req.addr, HBEC_CFG_DATA_PORT);
  assign data_port_rd = port_access(i_io_req.rd, i_io_req.addr, HBEC_CFG_DATA_PORT);

  hbec_cfg_addr #(
    .DEVICE_NUM   (DEVICE_NUM)
  ) u_cfg_addr (
    .i_sys_clk    (i_sys_clk),
    .i_reset      (i_reset),
    .i_addr_wr    (addr_port_wr),
    .i_be         (i_io_req.be),
    .i_wdata      (i_io_req.wdata),
    .o_cfg_addr_q (cfg_addr),
    .o_hit        (cfg_hit),
    .o_reg_ofs    (reg_ofs)
  );

  // ----------------------------------------------------------------
  // Register selects
  // ----------------------------------------------------------------
  logic ctrl_wr;
  logic status_wr;

  assign ctrl_wr   = data_port_wr && cfg_hit && (reg_ofs == HBEC_OFS_CTRL);
  assign status_wr = data_port_wr && cfg_hit && (reg_ofs == HBEC_OFS_STATUS);

  // ----------------------------------------------------------------
  // Error detection and signalling
  // ----------------------------------------------------------------
  logic                         perr_rd;
  logic                         perr_wr;
  logic                         perr_addr;
  logic                         perr_any;
  logic                         serr_parity;
  logic                         serr_abort;
  logic [HBEC_STATUS_WIDTH-1:0] flag_set;
  logic [HBEC_STATUS_WIDTH-1:0] flag_clear;
  logic [HBEC_STATUS_WIDTH-1:0] flags;

  assign perr_rd     = i_pci_evt.rd_data_parity
                     && state_q.ctrl[HBEC_CTRL_PERR_RD_DATA];
  assign perr_wr     = i_pci_evt.wr_data_parity
                     && state_q.ctrl[HBEC_CTRL_PERR_WR_DATA];
  assign perr_addr   = i_pci_evt.addr_parity
                     && state_q.ctrl[HBEC_CTRL_PERR_ADDR];
  assign perr_any    = perr_rd || perr_wr || perr_addr;
  assign serr_parity = perr_any && state_q.ctrl[HBEC_CTRL_SERR_PARITY];
  assign serr_abort  = i_pci_evt.target_abort
                     && state_q.ctrl[HBEC_CTRL_SERR_TGT_ABORT];

  always_comb begin
    flag_set = '0;
    flag_set[HBEC_ST_RD_DATA_PARITY] = i_pci_evt.rd_data_parity;
    flag_set[HBEC_ST_WR_DATA_PARITY] = i_pci_evt.wr_data_parity;
    flag_set[HBEC_ST_ADDR_PARITY]    = i_pci_evt.addr_parity;
    flag_set[HBEC_ST_PARITY_SYSERR]  = serr_parity;
    flag_set[HBEC_ST_TGT_ABORT_SERR] = serr_abort;
  end

  // Only ones written through enabled byte lanes clear a flag
  assign flag_clear = status_wr
                    ? HBEC_STATUS_WIDTH'(i_io_req.wdata & hbec_be_mask(i_io_req.be))
                    : '0;

  hbec_sticky_flags #(
    .WIDTH     (HBEC_STATUS_WIDTH)
  ) u_flags (
    .i_sys_clk (i_sys_clk),
    .i_reset   (i_reset),
    .i_set     (flag_set),
    .i_clear   (flag_clear),
    .o_flags_q (flags)
  );

  // ----------------------------------------------------------------
  // Read data mux
  // ----------------------------------------------------------------
  logic [31:0] cfg_rdata;

  always_comb begin
    cfg_rdata = 32'h00000000;
    if (!cfg_hit) begin
      cfg_rdata = HBEC_UNMAPPED_READ;
    end else begin
      unique case (reg_ofs)
        (HBEC_OFS_HEADER_TYPE & HBEC_DWORD_MASK): begin
          cfg_rdata[HBEC_HEADER_LSB +: 8] = HBEC_HEADER_TYPE_VAL;
        end
        HBEC_OFS_CTRL: begin
          cfg_rdata = state_q.ctrl & HBEC_CTRL_WR_MASK;
        end
        HBEC_OFS_STATUS: begin
          cfg_rdata = {{(32 - HBEC_STATUS_WIDTH){1'b0}}, flags};
        end
        default: begin
          cfg_rdata = 32'h00000000;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [31:0] wmask;
    wmask   = hbec_be_mask(i_io_req.be) & HBEC_CTRL_WR_MASK;
    state_d = state_q;

    // Control register, writable bits only
    if (ctrl_wr) begin
      state_d.ctrl = (state_q.ctrl & ~wmask) | (i_io_req.wdata & wmask);
    end

    // Read response one cycle after the request
    state_d.rsp.valid = 1'b0;
    unique case (state_q.io_st)
      HBEC_IO_IDLE: begin
        state_d.rsp = read_answer(addr_port_rd, data_port_rd, cfg_addr, cfg_rdata, state_q.rsp);
        if (state_d.rsp.valid) begin
          state_d.io_st = HBEC_IO_RESP;
        end
      end
      HBEC_IO_RESP: begin
        state_d.rsp = read_answer(addr_port_rd, data_port_rd, cfg_addr, cfg_rdata, state_q.rsp);
        if (!state_d.rsp.valid) begin
          state_d.io_st = HBEC_IO_IDLE;
        end
      end
      default: begin
        state_d.io_st = HBEC_IO_IDLE;
      end
    endcase

    // PERR# low one cycle, then driven high one cycle before release
    state_d.perr_n  = !perr_any;
    state_d.perr_oe = perr_any || !state_q.perr_n;

    // SERR# is open drain: enabled only while low
    state_d.serr_n  = !(serr_parity || serr_abort);
    state_d.serr_oe = serr_parity || serr_abort;

    // Mode levels
    state_d.legacy      = state_q.ctrl[HBEC_CTRL_LEGACY_COMPAT];
    state_d.prefetch_en = state_q.ctrl[HBEC_CTRL_READ_PREFETCH];
    state_d.posting_en  = state_q.ctrl[HBEC_CTRL_WRITE_POSTING];

    // Burst decisions for PCI masters into system memory
    state_d.dec = burst_decide(i_burst_req, state_q.ctrl);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      state_q.io_st       <= HBEC_IO_IDLE;
      state_q.rsp         <= '0;
      state_q.ctrl        <= HBEC_CTRL_RESET;
      state_q.perr_n      <= 1'b1;
      state_q.perr_oe     <= 1'b0;
      state_q.serr_n      <= 1'b1;
      state_q.serr_oe     <= 1'b0;
      state_q.legacy      <= HBEC_CTRL_RESET[HBEC_CTRL_LEGACY_COMPAT];
      state_q.prefetch_en <= HBEC_CTRL_RESET[HBEC_CTRL_READ_PREFETCH];
      state_q.posting_en  <= HBEC_CTRL_RESET[HBEC_CTRL_WRITE_POSTING];
      state_q.dec         <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_io_rsp           = state_q.rsp;
  assign o_perr_n           = state_q.perr_n;
  assign o_perr_oe          = state_q.perr_oe;
  assign o_serr_n           = state_q.serr_n;
  assign o_serr_oe          = state_q.serr_oe;
  assign o_legacy_compat    = state_q.legacy;
  assign o_read_prefetch_en = state_q.prefetch_en;
  assign o_write_posting_en = state_q.posting_en;
  assign o_burst_dec        = state_q.dec;

endmodule : hbec_bridge_err_ctrl
`default_nettype wire

// ### tb/hbec_chk.sv
// Checker: port-level assertions of the bridge error-control bank
`timescale 1ns/1ps
`default_nettype none
module hbec_chk
  import hbec_pkg::*;
(
  input wire logic               i_sys_clk,
  input wire logic               i_reset,
  input wire hbec_io_req_type    i_io_req,
  input wire hbec_io_rsp_type    o_io_rsp,
  input wire hbec_pci_evt_type   i_pci_evt,
  input wire logic               o_perr_n,
  input wire logic               o_perr_oe,
  input wire logic               o_serr_n,
  input wire logic               o_serr_oe,
  input wire logic               o_legacy_compat,
  input wire logic               o_read_prefetch_en,
  input wire logic               o_write_posting_en,
  input wire hbec_burst_req_type i_burst_req,
  input wire hbec_burst_dec_type o_burst_dec
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_read_answer_lat: assert property (o_io_rsp.valid == $past(i_io_req.rd &&
    (i_io_req.addr == HBEC_CFG_ADDR_PORT || i_io_req.addr == HBEC_CFG_DATA_PORT)))
    else $error("read answer not one cycle after request");
  a_perr_has_cause: assert property (!o_perr_n |-> $past(i_pci_evt.rd_data_parity ||
    i_pci_evt.wr_data_parity || i_pci_evt.addr_parity))
    else $error("perr low without parity event");
  a_perr_drive_hold: assert property ($fell(o_perr_n) |-> o_perr_oe ##1 o_perr_oe)
    else $error("perr not driven two cycles");
  a_serr_has_cause: assert property (!o_serr_n |-> $past(|i_pci_evt))
    else $error("serr low without event");
  a_serr_oe_pair: assert property (o_serr_oe == !o_serr_n)
    else $error("serr enable mismatch");
  a_write_burst_dec: assert property (i_burst_req.valid && i_burst_req.to_sysmem &&
    i_burst_req.is_write |=> o_burst_dec.post == o_write_posting_en &&
    o_burst_dec.disconnect == !o_write_posting_en)
    else $error("write burst decision wrong");
  a_read_burst_dec: assert property (i_burst_req.valid && i_burst_req.to_sysmem &&
    !i_burst_req.is_write && i_burst_req.qword_aligned |=>
    o_burst_dec.prefetch == o_read_prefetch_en &&
    o_burst_dec.wait_complete == !o_read_prefetch_en)
    else $error("read burst decision wrong");
  a_idle_burst_dec: assert property (!(i_burst_req.valid && i_burst_req.to_sysmem)
    |=> o_burst_dec == '0)
    else $error("decision without system-memory burst");
  c_read_answer: cover property (o_io_rsp.valid);
  c_perr_low: cover property (!o_perr_n);
  c_serr_low: cover property (!o_serr_n);
  c_post_burst: cover property (o_burst_dec.post);
endmodule : hbec_chk
bind hbec_bridge_err_ctrl hbec_chk i_hbec_chk (.i_sys_clk, .i_reset, .i_io_req, .o_io_rsp,
  .i_pci_evt, .o_perr_n, .o_perr_oe, .o_serr_n, .o_serr_oe, .o_legacy_compat,
  .o_read_prefetch_en, .o_write_posting_en, .i_burst_req, .o_burst_dec);
`default_nettype wire

// ### tb/hbec_pci_model.sv
// Partner: PCI masters and targets raising error events and bursts
`timescale 1ns/1ps
`default_nettype none
module hbec_pci_model
  import hbec_pkg::*;
(
  input  wire logic               i_sys_clk,
  output hbec_pci_evt_type        o_pci_evt,
  output hbec_burst_req_type      o_burst_req,
  input  wire hbec_burst_dec_type i_burst_dec
);
  initial begin
    o_pci_evt = '0;
    o_burst_req = '0;
  end
  // One-cycle error event pulse
  task automatic pulse(input hbec_pci_evt_type e);
    @(negedge i_sys_clk) o_pci_evt = e;
    @(negedge i_sys_clk) o_pci_evt = '0;
  endtask : pulse
  // One-cycle burst request, decision taken one cycle later
  task automatic burst(input hbec_burst_req_type r, output hbec_burst_dec_type d);
    @(negedge i_sys_clk) o_burst_req = r;
    @(negedge i_sys_clk) d = i_burst_dec;
    o_burst_req = '0;
  endtask : burst
endmodule : hbec_pci_model
`default_nettype wire

// ### tb/tb_top.sv
// Testbench: register, event and burst scenarios of the error-control bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import hbec_pkg::*;
  logic               i_sys_clk = 1'b0;
  logic               i_reset   = 1'b1;
  hbec_io_req_type    req       = '0;
  hbec_io_rsp_type    rsp;
  hbec_pci_evt_type   evt;
  hbec_burst_req_type breq;
  hbec_burst_dec_type bdec;
  hbec_burst_dec_type bd;
  logic               perr_n, perr_oe, serr_n, serr_oe, leg, rpf, wpo;
  int                 error_cnt = 0;
  int                 checks = 0;
  logic [31:0]        d;
  logic [3:0]         e;
  logic [31:0]        ctl[4] = '{32'h0, 32'h00700000, 32'h00500000, 32'h00200000};
  logic [3:0]         brq[4] = '{4'b1111, 4'b1011, 4'b1001, 4'b1110};
  always #2 i_sys_clk = ~i_sys_clk;
  hbec_bridge_err_ctrl i_hbec_bridge_err_ctrl (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
    .i_io_req(req), .o_io_rsp(rsp), .i_pci_evt(evt), .o_perr_n(perr_n),
    .o_perr_oe(perr_oe), .o_serr_n(serr_n), .o_serr_oe(serr_oe), .o_legacy_compat(leg),
    .o_read_prefetch_en(rpf), .o_write_posting_en(wpo), .i_burst_req(breq),
    .o_burst_dec(bdec));
  hbec_pci_model i_hbec_pci_model (.i_sys_clk(i_sys_clk), .o_pci_evt(evt),
    .o_burst_req(breq), .i_burst_dec(bdec));
  // ----------------------------------------------------------------
  // Compare, access and closing tasks
  // ----------------------------------------------------------------
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_val
  task automatic chk_pin(input logic got, input logic exp);
    chk_val({31'h0, got}, {31'h0, exp});
  endtask : chk_pin
  task automatic io(input logic wr, input logic [15:0] a, input logic [31:0] wd);
    @(negedge i_sys_clk) req = '{wr: wr, rd: !wr, addr: a, be: 4'hf, wdata: wd};
    @(negedge i_sys_clk) req = '0;
    if (!wr) chk_pin(rsp.valid, 1'b1);
    d = rsp.rdata;
  endtask : io
  task automatic cfg_wr(input logic [7:0] ofs, input logic [31:0] wd);
    io(1'b1, HBEC_CFG_ADDR_PORT, {24'h800000, ofs});
    io(1'b1, HBEC_CFG_DATA_PORT, wd);
  endtask : cfg_wr
  task automatic cfg_rd(input logic [7:0] ofs, input logic [31:0] exp);
    io(1'b1, HBEC_CFG_ADDR_PORT, {24'h800000, ofs});
    io(1'b0, HBEC_CFG_DATA_PORT, 32'h0);
    chk_val(d, exp);
  endtask : cfg_rd
  task automatic finish_test;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test
  function automatic logic [3:0] exp_dec(input logic [3:0] r, input logic [31:0] c);
    if (!(r[3] && r[0])) return 4'h0;
    if (r[2]) return c[20] ? 4'b0100 : 4'b0011;
    return c[21] ? {r[1], 3'b000} : 4'b0011;
  endfunction : exp_dec
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge i_sys_clk);
    error_cnt++;
    finish_test();
  end
  initial begin
    repeat (10) @(negedge i_sys_clk);
    i_reset = 1'b0;
    chk_pin(perr_n & serr_n & !perr_oe & !serr_oe, 1'b1);
    cfg_rd(HBEC_OFS_CTRL, 32'h0);
    cfg_rd(HBEC_OFS_STATUS, 32'h0);
    cfg_wr(8'h0c, 32'hffffffff);
    cfg_rd(8'h0c, 32'h0);
    cfg_wr(HBEC_OFS_CTRL, 32'hffffffff);
    cfg_rd(HBEC_OFS_CTRL, 32'h0070001f);
    cfg_wr(HBEC_OFS_STATUS, 32'hffffffff);
    cfg_rd(HBEC_OFS_STATUS, 32'h0);
    cfg_rd(8'h40, 32'h0);
    io(1'b1, HBEC_CFG_ADDR_PORT, 32'h00000050);
    io(1'b0, HBEC_CFG_DATA_PORT, 32'h0);
    chk_val(d, 32'hffffffff);
    io(1'b1, HBEC_CFG_ADDR_PORT, 32'h80000850);
    io(1'b1, HBEC_CFG_DATA_PORT, 32'h0);
    cfg_rd(HBEC_OFS_CTRL, 32'h0070001f);
    foreach (ctl[i]) begin
      cfg_wr(HBEC_OFS_CTRL, ctl[i]);
      foreach (brq[j]) begin
        i_hbec_pci_model.burst(brq[j], bd);
        chk_val({28'h0, bd}, {28'h0, exp_dec(brq[j], ctl[i])});
        chk_val({29'h0, leg, rpf, wpo}, {29'h0, ctl[i][22:20]});
      end
    end
    foreach (ctl[i]) begin
      cfg_wr(HBEC_OFS_CTRL, i[0] ? 32'h0 : 32'h1f);
      for (int k = 0; k < 4; k++) begin
        e = 4'h8 >> k;
        cfg_wr(HBEC_OFS_STATUS, 32'h1f);
        i_hbec_pci_model.pulse(e);
        d = {27'h0, e[3:1], |e[3:1] & !i[0], e[0] & !i[0]};
        chk_pin(perr_n, !(|e[3:1] && !i[0]));
        chk_pin(serr_n, !(d[1] | d[0]));
        cfg_rd(HBEC_OFS_STATUS, d);
        cfg_wr(HBEC_OFS_STATUS, 32'h0);
        cfg_rd(HBEC_OFS_STATUS, {27'h0, e[3:1], |e[3:1] & !i[0], e[0] & !i[0]});
        cfg_wr(HBEC_OFS_STATUS, 32'h1f);
        cfg_rd(HBEC_OFS_STATUS, 32'h0);
      end
    end
    io(1'b1, HBEC_CFG_ADDR_PORT, 32'h80000054);
    fork
      i_hbec_pci_model.pulse(4'h8);
      io(1'b1, HBEC_CFG_DATA_PORT, 32'h1f);
    join
    cfg_rd(HBEC_OFS_STATUS, 32'h10);
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
